//--- ubsfr_checker.sv
/*
  Port checker for ubsfr_top.
  Assumes a single pclk domain with presetn as reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ubsfr_checker #(
  parameter bit PIN28 = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_bor_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pc_load,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic [4:0] pc_high,
  input wire logic [7:0] pc_low_byte,
  input wire logic [1:0] direct_bank_select,
  input wire logic nvm_unlock_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready && !paddr[10]; endproperty
  a_err: assert property (p_err) else $error("error on mapped address");
  property p_hole; PIN28 && pready && !pwrite && paddr[10:2] inside {9'h108, 9'h109, 9'h188, 9'h189}
    |-> prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("absent port read nonzero");
  property p_pch; $changed(pc_high) |-> $past(pc_load) || !$past(por_bor_n) || (pready && pwrite); endproperty
  a_pch: assert property (p_pch) else $error("pc high moved without load");
  property p_bank; $changed(direct_bank_select) |-> (pready && pwrite) || $past(pready && pwrite)
    || !$past(por_bor_n); endproperty
  a_bank: assert property (p_bank) else $error("bank select moved without write");
  property p_por; !por_bor_n |=> pc_low_byte == 8'h00 && direct_bank_select == 2'h0; endproperty
  a_por: assert property (p_por) else $error("power-on values wrong");
  property p_unlock; nvm_unlock_strobe |-> $past(psel && pwrite && paddr[10:2] == ubsfr_pkg::A_NVM_UNLOCK);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock strobe without write");
  property p_we; mem_we |-> $past(psel && pwrite && paddr[10] && paddr[8:2] == 7'h00)
    && mem_wdata == $past(pwdata[7:0]); endproperty
  a_we: assert property (p_we) else $error("memory write without indirect write");
endmodule : ubsfr_checker
bind ubsfr_top ubsfr_checker #(.PIN28(PIN28)) i_ubsfr_checker (.pclk(pclk), .presetn(presetn),
  .por_bor_n(por_bor_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_load(pc_load), .mem_wdata(mem_wdata),
  .mem_we(mem_we), .pc_high(pc_high), .pc_low_byte(pc_low_byte), .direct_bank_select(direct_bank_select),
  .nvm_unlock_strobe(nvm_unlock_strobe));
`default_nettype wire

//--- ubsfr_decode.sv
/*
  Address decoder for the upper banks: folds mirrored locations onto one offset.
  Assumes a 9-bit register address.
*/
`timescale 1ns/1ps
`default_nettype none
module ubsfr_decode (
  input wire logic [8:0] addr,
  output logic mirrored,
  output logic [6:0] ofs
);
  always_comb begin
    ofs = addr[6:0] & ubsfr_pkg::MIRROR_OFS_MASK;
    case (ofs)
      ubsfr_pkg::OFS_IAP, ubsfr_pkg::OFS_PC_LOW, ubsfr_pkg::OFS_FLAGS, ubsfr_pkg::OFS_PTR, ubsfr_pkg::OFS_PCH,
      ubsfr_pkg::OFS_IRQ: mirrored = 1'b1; // RULE3
      default: mirrored = 1'b0;
    endcase
  end
endmodule : ubsfr_decode
`default_nettype wire

//--- ubsfr_mem_model.sv
/*
  Data memory model answering indirect accesses of the upper bank block.
  Assumes the block drives mem_addr, mem_wdata and mem_we on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ubsfr_mem_model (
  input wire logic pclk,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [512];
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'(i * 7 + 3);
  end
  // Store on write pulse
  always @(posedge pclk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
  end
  // Read data follows the address at once
  assign mem_rdata = mem[mem_addr];
endmodule : ubsfr_mem_model
`default_nettype wire

//--- ubsfr_pkg.sv
/*
  Constants for the upper special function register bank block: addresses, field
  positions and reset values.
  Assumes a 9-bit register address from the core, held on APB as a byte address of four times it.
*/
// What this block does
// RULE1: pc high latch holds five counter bits, moved into the counter on a load.
// RULE2: indirect port reaches the data location addressed by the indirect pointer.
// RULE3: indirect port, pc low, flags, pointer, pc latch, irq control mirrored in every bank.
// RULE4: power-on or brown-out reset values differ from those of other resets.
// RULE5: unimplemented locations and bits read zero; writes to them are ignored.
// RULE6: 28-pin variant lacks port D, port E and their directions; they read zero.
// RULE7: nvm unlock location stores nothing; it is only a write target.
// RULE8: software keeps the parallel port irq enable and flag clear on 28-pin parts.
// RULE9: two bank-select bits choose one of four 128-byte banks; 11 selects 180h-1FFh.
// RULE10: unknown reset fields are unspecified; unchanged fields keep content on other resets.
package ubsfr_pkg;
  localparam logic [8:0] A_IAP_B2 = 9'h100;
  localparam logic [8:0] A_TIMER0 = 9'h101;
  localparam logic [8:0] A_PC_LOW_B2 = 9'h102;
  localparam logic [8:0] A_FLAGS_B2 = 9'h103;
  localparam logic [8:0] A_PTR_B2 = 9'h104;
  localparam logic [8:0] A_PB_LATCH = 9'h106;
  localparam logic [8:0] A_PD_LATCH = 9'h108;
  localparam logic [8:0] A_PE_LATCH = 9'h109;
  localparam logic [8:0] A_PCH_B2 = 9'h10A;
  localparam logic [8:0] A_IRQ_B2 = 9'h10B;
  localparam logic [8:0] A_NVM_DL = 9'h10C;
  localparam logic [8:0] A_NVM_AL = 9'h10D;
  localparam logic [8:0] A_NVM_DH = 9'h10E;
  localparam logic [8:0] A_NVM_AH = 9'h10F;
  localparam logic [8:0] A_IAP_B3 = 9'h180;
  localparam logic [8:0] A_OPTION = 9'h181;
  localparam logic [8:0] A_PC_LOW_B3 = 9'h182;
  localparam logic [8:0] A_FLAGS_B3 = 9'h183;
  localparam logic [8:0] A_PTR_B3 = 9'h184;
  localparam logic [8:0] A_PB_DIR = 9'h186;
  localparam logic [8:0] A_PD_DIR = 9'h188;
  localparam logic [8:0] A_PE_DIR = 9'h189;
  localparam logic [8:0] A_PCH_B3 = 9'h18A;
  localparam logic [8:0] A_IRQ_B3 = 9'h18B;
  localparam logic [8:0] A_NVM_CTL = 9'h18C;
  localparam logic [8:0] A_NVM_UNLOCK = 9'h18D;
  localparam logic [8:0] A_RSVD_A = 9'h18E;
  localparam logic [8:0] A_RSVD_B = 9'h18F;
  localparam logic [8:0] A_CTRL = 9'h1F0;
  localparam logic [8:0] A_PC_HI_VIEW = 9'h1F1;
  localparam logic [8:0] A_STATE = 9'h1F2;
  localparam logic [6:0] MIRROR_OFS_MASK = 7'h7F;
  localparam logic [6:0] OFS_IAP = 7'h00;
  localparam logic [6:0] OFS_PC_LOW = 7'h02;
  localparam logic [6:0] OFS_FLAGS = 7'h03;
  localparam logic [6:0] OFS_PTR = 7'h04;
  localparam logic [6:0] OFS_PCH = 7'h0A;
  localparam logic [6:0] OFS_IRQ = 7'h0B;
  localparam logic [7:0] PCH_MASK = 8'h1F;
  localparam logic [7:0] DH_MASK = 8'h3F;
  localparam logic [7:0] AH_MASK = 8'h1F;
  localparam logic [7:0] NVMC_MASK = 8'h8F;
  localparam logic [7:0] NVMC_KEEP = 8'h88;
  localparam logic [7:0] FLAGS_WR_MASK = 8'hE7;
  localparam logic [7:0] FLAGS_POR = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] PE_DIR_RST = 8'h07;
  localparam logic [7:0] PE_DIR_MASK = 8'hF7;
  localparam logic [7:0] PE_MASK = 8'h07;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int FLAG_TO = 4;
  localparam int FLAG_PD = 3;
  localparam int BANK_HI = 6;
  localparam int BANK_LO = 5;
  localparam int IRP_BIT = 7;
  localparam logic [1:0] BANK3 = 2'h3;
endpackage : ubsfr_pkg

//--- ubsfr_top.sv
/*
  Upper bank special function register map with APB slave.
  Assumes an APB master on pclk; indirect accesses are forwarded to a data memory port
  that answers with mem_rdata in the same cycle.
*/
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ubsfr_top #(
  parameter bit PIN28 = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_bor_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pc_load,
  input wire logic wdt_timeout,
  input wire logic [7:0] mem_rdata,
  output logic [8:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output logic [4:0] pc_high,
  output logic [7:0] pc_low_byte,
  output logic [1:0] direct_bank_select,
  output logic [7:0] option_out,
  output logic [7:0] port_b_direction_out,
  output logic [7:0] port_b_latch_out,
  output logic nvm_unlock_strobe
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [8:0] maddr;
    logic [7:0] mwdata;
    logic mwe;
    logic mre;
    logic unlock;
    logic [4:0] pch_live;
    logic [7:0] pc_lo;
    logic [7:0] flags;
    logic [7:0] ptr;
    logic [7:0] pch;
    logic [7:0] irq;
    logic [7:0] timer0;
    logic [7:0] pb_latch;
    logic [7:0] pb_dir;
    logic [7:0] pd_latch;
    logic [7:0] pd_dir;
    logic [7:0] pe_latch;
    logic [7:0] pe_dir;
    logic [7:0] option;
    logic [7:0] dl;
    logic [7:0] al;
    logic [7:0] dh;
    logic [7:0] ah;
    logic [7:0] nvmc;
    logic por_seen;
  } ubsfr_state_t;

  ubsfr_state_t state_reg;
  ubsfr_state_t state_next;
  logic mirrored;
  logic [6:0] ofs;
  logic [8:0] reg_addr;

  assign reg_addr = paddr[10:2];

  ubsfr_decode u_dec (
    .addr(reg_addr),
    .mirrored(mirrored),
    .ofs(ofs)
  );

  function automatic logic [8:0] canon(input logic [8:0] a, input logic mir);
    canon = mir ? {2'b10, a[6:0]} : a;
  endfunction : canon

  logic [8:0] ca;
  logic [7:0] wb;
  logic [7:0] rd;
  logic hit;
  logic access;

  assign ca = canon(reg_addr, mirrored);
  assign wb = pwdata[7:0];
  assign access = psel && penable && !state_reg.ready;

  always_comb begin
    hit = 1'b1;
    rd = ubsfr_pkg::ZERO8;
    case (ca)
      ubsfr_pkg::A_IAP_B2: rd = mem_rdata; // RULE2
      ubsfr_pkg::A_TIMER0: rd = state_reg.timer0;
      ubsfr_pkg::A_PC_LOW_B2: rd = state_reg.pc_lo;
      ubsfr_pkg::A_FLAGS_B2: rd = state_reg.flags;
      ubsfr_pkg::A_PTR_B2: rd = state_reg.ptr;
      ubsfr_pkg::A_PB_LATCH: rd = state_reg.pb_latch;
      ubsfr_pkg::A_PD_LATCH: rd = PIN28 ? ubsfr_pkg::ZERO8 : state_reg.pd_latch; // RULE6
      ubsfr_pkg::A_PE_LATCH: rd = PIN28 ? ubsfr_pkg::ZERO8 : state_reg.pe_latch; // RULE6
      ubsfr_pkg::A_PCH_B2: rd = state_reg.pch & ubsfr_pkg::PCH_MASK; // RULE5
      ubsfr_pkg::A_IRQ_B2: rd = state_reg.irq;
      ubsfr_pkg::A_NVM_DL: rd = state_reg.dl;
      ubsfr_pkg::A_NVM_AL: rd = state_reg.al;
      ubsfr_pkg::A_NVM_DH: rd = state_reg.dh & ubsfr_pkg::DH_MASK; // RULE5
      ubsfr_pkg::A_NVM_AH: rd = state_reg.ah & ubsfr_pkg::AH_MASK; // RULE5
      ubsfr_pkg::A_OPTION: rd = state_reg.option;
      ubsfr_pkg::A_PB_DIR: rd = state_reg.pb_dir;
      ubsfr_pkg::A_PD_DIR: rd = PIN28 ? ubsfr_pkg::ZERO8 : state_reg.pd_dir; // RULE6
      ubsfr_pkg::A_PE_DIR: rd = PIN28 ? ubsfr_pkg::ZERO8 : state_reg.pe_dir; // RULE6
      ubsfr_pkg::A_NVM_CTL: rd = state_reg.nvmc & ubsfr_pkg::NVMC_MASK; // RULE5
      ubsfr_pkg::A_NVM_UNLOCK: rd = ubsfr_pkg::ZERO8; // RULE7
      ubsfr_pkg::A_RSVD_A, ubsfr_pkg::A_RSVD_B: rd = ubsfr_pkg::ZERO8;
      ubsfr_pkg::A_CTRL: rd = {7'h00, state_reg.por_seen};
      ubsfr_pkg::A_PC_HI_VIEW: rd = {3'h0, state_reg.pch_live};
      default: begin
        rd = ubsfr_pkg::ZERO8; // RULE5
        hit = reg_addr >= ubsfr_pkg::A_IAP_B2 && reg_addr[8:7] != 2'b00;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.ready = 1'b0;
    state_next.err = 1'b0;
    state_next.mwe = 1'b0;
    state_next.mre = 1'b0;
    state_next.unlock = 1'b0;
    state_next.maddr = {state_reg.flags[ubsfr_pkg::IRP_BIT], state_reg.ptr}; // RULE2
    state_next.mwdata = wb;
    if (pc_load) begin
      state_next.pch_live = state_reg.pch[4:0]; // RULE1
    end
    if (wdt_timeout) begin
      state_next.flags[ubsfr_pkg::FLAG_TO] = 1'b0;
    end
    if (access) begin
      state_next.ready = 1'b1;
      state_next.err = !hit;
      state_next.rdata = {24'h000000, rd};
      if (ca == ubsfr_pkg::A_IAP_B2) begin
        state_next.mwe = pwrite; // RULE2
        state_next.mre = !pwrite;
      end
      if (pwrite) begin
        case (ca)
          ubsfr_pkg::A_TIMER0: state_next.timer0 = wb;
          ubsfr_pkg::A_PC_LOW_B2: begin
            state_next.pc_lo = wb;
            state_next.pch_live = state_reg.pch[4:0]; // RULE1
          end
          ubsfr_pkg::A_FLAGS_B2: begin
            state_next.flags = (state_reg.flags & ~ubsfr_pkg::FLAGS_WR_MASK) | (wb & ubsfr_pkg::FLAGS_WR_MASK);
          end
          ubsfr_pkg::A_PTR_B2: state_next.ptr = wb;
          ubsfr_pkg::A_PB_LATCH: state_next.pb_latch = wb;
          ubsfr_pkg::A_PD_LATCH: state_next.pd_latch = PIN28 ? ubsfr_pkg::ZERO8 : wb; // RULE6
          ubsfr_pkg::A_PE_LATCH: state_next.pe_latch = PIN28 ? ubsfr_pkg::ZERO8 : wb & ubsfr_pkg::PE_MASK; // RULE6
          ubsfr_pkg::A_PCH_B2: state_next.pch = wb & ubsfr_pkg::PCH_MASK; // RULE5
          ubsfr_pkg::A_IRQ_B2: state_next.irq = wb;
          ubsfr_pkg::A_NVM_DL: state_next.dl = wb;
          ubsfr_pkg::A_NVM_AL: state_next.al = wb;
          ubsfr_pkg::A_NVM_DH: state_next.dh = wb & ubsfr_pkg::DH_MASK; // RULE5
          ubsfr_pkg::A_NVM_AH: state_next.ah = wb & ubsfr_pkg::AH_MASK; // RULE5
          ubsfr_pkg::A_OPTION: state_next.option = wb;
          ubsfr_pkg::A_PB_DIR: state_next.pb_dir = wb;
          ubsfr_pkg::A_PD_DIR: state_next.pd_dir = PIN28 ? ubsfr_pkg::ZERO8 : wb; // RULE6
          ubsfr_pkg::A_PE_DIR: begin
            state_next.pe_dir = PIN28 ? ubsfr_pkg::ZERO8 : wb & ubsfr_pkg::PE_DIR_MASK; // RULE6
          end
          ubsfr_pkg::A_NVM_CTL: state_next.nvmc = wb & ubsfr_pkg::NVMC_MASK; // RULE5
          ubsfr_pkg::A_NVM_UNLOCK: state_next.unlock = 1'b1; // RULE7
          ubsfr_pkg::A_CTRL: state_next.por_seen = wb[0] ? 1'b0 : state_reg.por_seen;
          default: state_next.unlock = 1'b0; // RULE5
        endcase
      end
    end
  end

  // Power-on or brown-out loads the first set; other resets keep the unchanged fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.rdata <= 32'h00000000;
      state_reg.ready <= 1'b0;
      state_reg.err <= 1'b0;
      state_reg.maddr <= 9'h000;
      state_reg.mwdata <= ubsfr_pkg::ZERO8;
      state_reg.mwe <= 1'b0;
      state_reg.mre <= 1'b0;
      state_reg.unlock <= 1'b0;
      state_reg.pch_live <= 5'h00; // RULE1
      state_reg.pc_lo <= ubsfr_pkg::ZERO8; // RULE4
      state_reg.pch <= ubsfr_pkg::ZERO8; // RULE4
      state_reg.flags[ubsfr_pkg::IRP_BIT:ubsfr_pkg::BANK_LO] <= 3'h0; // RULE4 RULE10
      state_reg.irq[7:1] <= 7'h00; // RULE10
      state_reg.option <= ubsfr_pkg::OPTION_RST;
      state_reg.pb_dir <= ubsfr_pkg::DIR_RST;
      state_reg.pd_dir <= ubsfr_pkg::DIR_RST;
      state_reg.pe_dir <= ubsfr_pkg::PE_DIR_RST;
      state_reg.nvmc[2:0] <= 3'h0; // RULE10
      state_reg.por_seen <= 1'b0;
    end else if (!por_bor_n) begin
      state_reg <= state_next;
      state_reg.por_seen <= 1'b1; // RULE4
      state_reg.flags <= ubsfr_pkg::FLAGS_POR; // RULE4
      state_reg.irq <= ubsfr_pkg::ZERO8;
      state_reg.nvmc <= ubsfr_pkg::ZERO8;
      state_reg.pc_lo <= ubsfr_pkg::ZERO8;
      state_reg.pch <= ubsfr_pkg::ZERO8;
      state_reg.pch_live <= 5'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Other resets (presetn) keep pointer, timer, port latches, nvm data and the unchanged flag bits

  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign mem_addr = state_reg.maddr;
  assign mem_wdata = state_reg.mwdata;
  assign mem_we = state_reg.mwe;
  assign mem_re = state_reg.mre;
  assign pc_high = state_reg.pch_live;
  assign pc_low_byte = state_reg.pc_lo;
  assign direct_bank_select = state_reg.flags[ubsfr_pkg::BANK_HI:ubsfr_pkg::BANK_LO]; // RULE9
  assign option_out = state_reg.option;
  assign port_b_direction_out = state_reg.pb_dir;
  assign port_b_latch_out = state_reg.pb_latch;
  assign nvm_unlock_strobe = state_reg.unlock; // RULE7
endmodule : ubsfr_top
`default_nettype wire

//--- upper_bank_sfr_map_tb.sv
/*
  Self-checking bench for ubsfr_top against a register model.
  Assumes ubsfr_mem_model as the data memory.
*/
`timescale 1ns/1ps
`default_nettype none
module upper_bank_sfr_map_tb;
  logic pclk = 0, presetn = 0, por_bor_n = 0, psel = 0, penable = 0, pwrite = 0, pc_load = 0, wdt_timeout = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, mem_we, mem_re, unl, er;
  logic [7:0] mem_rdata, mem_wdata, pc_low_byte_b2, opt, pbd, pbl, d, v;
  logic [8:0] mem_addr;
  logic [4:0] pch;
  logic [1:0] dbs;
  logic [7:0] mdl [int];
  logic [7:0] bmem [512];
  logic [8:0] rl [8] = '{9'h103, 9'h181, 9'h186, 9'h10A, 9'h182, 9'h18B, 9'h18E, 9'h18F};
  logic [8:0] wl [14] = '{9'h101, 9'h102, 9'h183, 9'h184, 9'h106, 9'h18A, 9'h18B, 9'h10C, 9'h10D, 9'h10E,
    9'h10F, 9'h181, 9'h186, 9'h18C};
  logic [8:0] hl [9] = '{9'h105, 9'h107, 9'h108, 9'h109, 9'h185, 9'h187, 9'h188, 9'h189, 9'h18D};
  int errors = 0, total_checks = 0;
  ubsfr_top #(.PIN28(1'b1)) i_ubsfr_top (.pclk(pclk), .presetn(presetn), .por_bor_n(por_bor_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_load(pc_load), .wdt_timeout(wdt_timeout), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .pc_high(pch), .pc_low_byte(pc_low_byte_b2),
    .direct_bank_select(dbs), .option_out(opt), .port_b_direction_out(pbd), .port_b_latch_out(pbl),
    .nvm_unlock_strobe(unl));
  ubsfr_mem_model i_ubsfr_mem_model (.pclk(pclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata));
  initial forever #12.5 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  function automatic logic [8:0] canon(input logic [8:0] a);
    return (a[8] && a[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B}) ? {2'b10, a[6:0]} : a;
  endfunction : canon
  function automatic logic [7:0] ex(input logic [8:0] a);
    return mdl.exists(canon(a)) ? mdl[canon(a)] : 8'h00;
  endfunction : ex
  function automatic logic [7:0] wm(input logic [8:0] a);
    case (canon(a))
      9'h10A, 9'h10F: return 8'h1F;
      9'h103: return 8'hE7;
      9'h10E: return 8'h3F;
      9'h18C: return 8'h8F;
      9'h101, 9'h102, 9'h104, 9'h106, 9'h10B, 9'h10C, 9'h10D, 9'h181, 9'h186: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : wm
  task automatic xfer(input logic wr, input logic [8:0] a, input logic [7:0] dd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {1'b0, a, 2'b00};
    pwdata <= {24'h0, dd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(er), 32'(a < 9'h100));
    if (wr && canon(a) != 9'h100) mdl[canon(a)] = (ex(a) & ~wm(a)) | (dd & wm(a));
  endtask : xfer
  task automatic rc(input logic [8:0] a);
    xfer(1'b0, a, 8'h00);
    check(rd, {24'h0, ex(a)});
  endtask : rc
  task automatic do_reset();
    presetn <= 1'b0;
    por_bor_n <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    por_bor_n <= 1'b1;
    mdl.delete();
    mdl[9'h103] = 8'h18;
    mdl[9'h181] = 8'hFF;
    mdl[9'h186] = 8'hFF;
  endtask : do_reset
  initial begin
    void'($urandom(66129));
    for (int i = 0; i < 512; i++) bmem[i] = 8'(i * 7 + 3);
    do_reset();
    foreach (rl[k]) rc(rl[k]);
    check(32'(opt), 32'hFF);
    foreach (wl[k]) begin
      d = 8'($urandom) & ((wl[k] == 9'h18C) ? 8'hFC : 8'hFF);
      xfer(1'b1, wl[k], d);
      rc(wl[k]);
      rc(canon(wl[k]));
    end
    check(32'(dbs), 32'(mdl[9'h103][6:5]));
    check({pc_low_byte_b2, opt, pbd, pbl}, {mdl[9'h102], mdl[9'h181], mdl[9'h186], mdl[9'h106]});
    foreach (hl[k]) begin
      xfer(1'b1, hl[k], 8'hFF);
      rc(hl[k]);
    end
    d = 8'($urandom);
    xfer(1'b1, 9'h18A, d);
    pc_load <= 1'b1;
    @(posedge pclk);
    pc_load <= 1'b0;
    @(posedge pclk);
    check(32'(pch), 32'(d[4:0]));
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      v = 8'($urandom);
      xfer(1'b1, 9'h104, d);
      xfer(1'b1, 9'h183, {k[0], 7'h00});
      xfer(1'b0, 9'h100, 8'h00);
      check(rd, {24'h0, bmem[{k[0], d}]});
      xfer(1'b1, 9'h180, v);
      bmem[{k[0], d}] = v;
      xfer(1'b0, 9'h100, 8'h00);
      check(rd, {24'h0, v});
    end
    xfer(1'b0, 9'h050, 8'h00);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    mdl[9'h103] &= 8'hEF;
    rc(9'h103);
    xfer(1'b1, 9'h10B, 8'h3C);
    por_bor_n <= 1'b0;
    @(posedge pclk);
    por_bor_n <= 1'b1;
    mdl[9'h103] = 8'h18;
    mdl[9'h10B] = 8'h00;
    mdl[9'h102] = 8'h00;
    mdl[9'h10A] = 8'h00;
    foreach (rl[k]) rc(rl[k]);
    rc(9'h104);
    do_reset();
    foreach (rl[k]) rc(rl[k]);
    conclude();
  end
endmodule : upper_bank_sfr_map_tb
`default_nettype wire
